// ---- rtl/hpa_regs.svh ----
`ifndef HPA_REGS_SVH
`define HPA_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HPA_OFF_WR_ADDR 12'h000
`define HPA_OFF_RD_ADDR 12'h004
`define HPA_OFF_CTRL 12'h008

// ****************************************
// reset values and control fields
// ****************************************
`define HPA_ADDR_RST 32'h00008000
`define HPA_CTRL_RST 32'h00000000
`define HPA_CTRL_MASK 32'h00000a01
`define HPA_CTRL_ORDER_BIT 0
`define HPA_CTRL_DUAL_BIT 9
`define HPA_CTRL_SEL_BIT 11

`endif

// ---- rtl/hpa_pkg.sv ----
`default_nettype none

package hpa_pkg;

    // ****************************************
    // apb register decode
    // ****************************************
    typedef enum logic [1:0]
    {
        HPA_SEL_NONE = 2'b00,
        HPA_SEL_WR = 2'b01,
        HPA_SEL_RD = 2'b10,
        HPA_SEL_CTRL = 2'b11
    } hpa_reg_sel_t;

    typedef logic [31:0] hpa_word_t;
    typedef logic [15:0] hpa_half_t;

endpackage : hpa_pkg

`default_nettype wire

// ---- rtl/hpa_addr_regs.sv ----
// How it works
// - two independent 32-bit registers hold the host write address and the host read address.
// - a control bit makes the pair look to the host like one shared register or like two.
// - the write address register takes any 32-bit value and resets to 0000_8000 hex.
// - the read address register takes any 32-bit value and resets to 0000_8000 hex.
// - with dual_address_enable at 0 the host sees one register, at 1 it sees two.
// - in dual mode host address accesses go to the write register on select 0, read on 1.
// - the internal processor reaches each address register on its own in any mode.
// - halfword_order 0 puts the most significant half first, 1 the least significant half.
`include "hpa_regs.svh"
`default_nettype none

module hpa_addr_regs
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire hpa_pkg::hpa_word_t pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host address halfword access
    input wire logic host_addr_wr,
    input wire logic host_addr_rd,
    input wire logic host_half_second,
    input wire hpa_pkg::hpa_half_t host_wdata,
    output logic [15:0] host_rdata,
    // addresses and modes to the data path
    output logic [31:0] write_address,
    output logic [31:0] read_address,
    output logic halfword_order,
    output logic dual_address_enable
);
    import hpa_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic hpa_reg_sel_t decode(input logic [11:0] addr);
        case (addr)
            `HPA_OFF_WR_ADDR: decode = HPA_SEL_WR;
            `HPA_OFF_RD_ADDR: decode = HPA_SEL_RD;
            `HPA_OFF_CTRL: decode = HPA_SEL_CTRL;
            default: decode = HPA_SEL_NONE;
        endcase
    endfunction : decode

    // true when this halfword is the upper half
    function automatic logic is_upper(input logic second, input logic order);
        is_upper = (second == order);
    endfunction : is_upper

    function automatic hpa_half_t pick_half(input hpa_word_t val, input logic upper);
        pick_half = upper ? val[31:16] : val[15:0];
    endfunction : pick_half

    function automatic hpa_word_t put_half(input hpa_word_t val, input hpa_half_t half,
        input logic upper);
        put_half = upper ? {half, val[15:0]} : {val[31:16], half};
    endfunction : put_half

    // ****************************************
    // state
    // ****************************************
    hpa_word_t wr_addr_ff;
    hpa_word_t nxt_wr_addr;
    hpa_word_t rd_addr_ff;
    hpa_word_t nxt_rd_addr;
    hpa_word_t ctrl_ff;
    hpa_word_t nxt_ctrl;
    hpa_word_t prdata_ff;
    hpa_word_t nxt_prdata;
    hpa_half_t host_rdata_ff;
    hpa_half_t nxt_host_rdata;

    hpa_reg_sel_t apb_sel;
    logic apb_wr;
    logic apb_setup_rd;
    logic order;
    logic dual;
    logic sel_rd;
    logic upper;
    logic host_to_wr;
    logic host_to_rd;

    assign apb_sel = decode(paddr);
    assign apb_wr = psel & penable & pwrite;
    assign apb_setup_rd = psel & ~penable & ~pwrite;
    assign order = ctrl_ff[`HPA_CTRL_ORDER_BIT];
    assign dual = ctrl_ff[`HPA_CTRL_DUAL_BIT];
    assign sel_rd = ctrl_ff[`HPA_CTRL_SEL_BIT];
    assign upper = is_upper(host_half_second, order);
    assign host_to_wr = ~dual | ~sel_rd;
    assign host_to_rd = ~dual | sel_rd;

    // ****************************************
    // apb answer
    // ****************************************
    assign pready = 1'b1;
    assign pslverr = psel & penable & (apb_sel == HPA_SEL_NONE);
    assign prdata = prdata_ff;

    // ****************************************
    // address and control registers
    // ****************************************
    always_comb
    begin
        nxt_wr_addr = wr_addr_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_ctrl = ctrl_ff;
        if (host_addr_wr && host_to_wr)
        begin
            nxt_wr_addr = put_half(wr_addr_ff, host_wdata, upper);
        end
        if (host_addr_wr && host_to_rd)
        begin
            nxt_rd_addr = put_half(rd_addr_ff, host_wdata, upper);
        end
        if (apb_wr)
        begin
            case (apb_sel)
                HPA_SEL_WR: nxt_wr_addr = pwdata;
                HPA_SEL_RD: nxt_rd_addr = pwdata;
                HPA_SEL_CTRL: nxt_ctrl = pwdata & `HPA_CTRL_MASK;
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_addr_ff <= `HPA_ADDR_RST;
            rd_addr_ff <= `HPA_ADDR_RST;
            ctrl_ff <= `HPA_CTRL_RST;
        end
        else
        begin
            wr_addr_ff <= nxt_wr_addr;
            rd_addr_ff <= nxt_rd_addr;
            ctrl_ff <= nxt_ctrl;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_comb
    begin
        nxt_prdata = prdata_ff;
        nxt_host_rdata = host_rdata_ff;
        if (apb_setup_rd)
        begin
            case (apb_sel)
                HPA_SEL_WR: nxt_prdata = wr_addr_ff;
                HPA_SEL_RD: nxt_prdata = rd_addr_ff;
                HPA_SEL_CTRL: nxt_prdata = ctrl_ff;
                default: nxt_prdata = 32'h00000000;
            endcase
        end
        if (host_addr_rd)
        begin
            nxt_host_rdata = pick_half(host_to_wr ? wr_addr_ff : rd_addr_ff, upper);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h00000000;
            host_rdata_ff <= 16'h0000;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
            host_rdata_ff <= nxt_host_rdata;
        end
    end

    assign host_rdata = host_rdata_ff;
    assign write_address = wr_addr_ff;
    assign read_address = rd_addr_ff;
    assign halfword_order = order;
    assign dual_address_enable = dual;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wr_reset_val_a: assert property ($rose(presetn) |-> wr_addr_ff == `HPA_ADDR_RST)
        else $error("write address reset value wrong");

    rd_reset_val_a: assert property ($rose(presetn) |-> rd_addr_ff == `HPA_ADDR_RST)
        else $error("read address reset value wrong");

    shared_load_a: assert property (host_addr_wr && !dual && !apb_wr |=>
        pick_half(wr_addr_ff, $past(upper)) == $past(host_wdata) &&
        pick_half(rd_addr_ff, $past(upper)) == $past(host_wdata))
        else $error("shared write did not load both registers alike");

    dual_wr_route_a: assert property (host_addr_wr && dual && !sel_rd && !apb_wr
        |=> $stable(rd_addr_ff))
        else $error("dual write with select 0 touched read address");

    dual_rd_route_a: assert property (host_addr_wr && dual && sel_rd && !apb_wr
        |=> $stable(wr_addr_ff))
        else $error("dual write with select 1 touched write address");

    cpu_separate_a: assert property (apb_wr && apb_sel == HPA_SEL_WR && !host_addr_wr
        |=> wr_addr_ff == $past(pwdata) && $stable(rd_addr_ff))
        else $error("processor write address access not separate");

    half_order_a: assert property (host_addr_wr && !apb_wr && host_to_wr
        |=> pick_half(wr_addr_ff, $past(upper)) == $past(host_wdata))
        else $error("halfword landed in wrong half");

    host_read_a: assert property (host_addr_rd && dual && sel_rd
        |=> host_rdata == pick_half($past(rd_addr_ff), $past(upper)))
        else $error("host read returned wrong address half");

    mode_shared_a: assert property (apb_wr && apb_sel == HPA_SEL_CTRL
        |=> dual == $past(pwdata[`HPA_CTRL_DUAL_BIT]))
        else $error("dual mode bit not loaded");

endmodule : hpa_addr_regs

`default_nettype wire

// ---- bench/hpa_host_model.sv ----
`default_nettype none

module hpa_host_model
(
    // clock
    input wire logic pclk,
    // host address port
    output logic host_addr_wr,
    output logic host_addr_rd,
    output logic host_half_second,
    output logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic halfword_order
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        host_addr_wr = 1'b0;
        host_addr_rd = 1'b0;
        host_half_second = 1'b0;
        host_wdata = 16'h5a5a;
    end

    // ****************************************
    // halfword pairing
    // ****************************************
    function automatic logic [15:0] half(input logic [31:0] w, input logic n);
        return (n == halfword_order) ? w[31:16] : w[15:0];
    endfunction : half

    task automatic put(input logic [31:0] a);
        logic [31:0] w;
        w = {a[31:2], 2'b00};
        @(posedge pclk);
        host_addr_wr <= 1'b1;
        host_half_second <= 1'b0;
        host_wdata <= half(w, 1'b0);
        @(posedge pclk);
        host_half_second <= 1'b1;
        host_wdata <= half(w, 1'b1);
        @(posedge pclk);
        host_addr_wr <= 1'b0;
        host_wdata <= ~half(w, 1'b1);
        @(posedge pclk);
    endtask : put

    task automatic get(output logic [31:0] w);
        logic [15:0] h1;
        @(posedge pclk);
        host_addr_rd <= 1'b1;
        host_half_second <= 1'b0;
        @(posedge pclk);
        host_half_second <= 1'b1;
        @(posedge pclk);
        h1 = host_rdata;
        host_addr_rd <= 1'b0;
        @(posedge pclk);
        w = halfword_order ? {host_rdata, h1} : {h1, host_rdata};
    endtask : get
endmodule : hpa_host_model

`default_nettype wire

// ---- bench/testbench.sv ----
`include "hpa_regs.svh"
`default_nettype none

module testbench import hpa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic host_addr_wr, host_addr_rd, host_half_second, halfword_order, dual_address_enable;
    logic [11:0] paddr;
    logic [15:0] host_wdata, host_rdata;
    logic [31:0] pwdata, prdata, write_address, read_address, rng, wr_m, rd_m, v, r;
    int err_total = 0;
    int compares = 0;

    hpa_addr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_addr_wr(host_addr_wr), .host_addr_rd(host_addr_rd),
        .host_half_second(host_half_second), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .write_address(write_address),
        .read_address(read_address), .halfword_order(halfword_order),
        .dual_address_enable(dual_address_enable));
    hpa_host_model host_u (.pclk(pclk), .host_addr_wr(host_addr_wr),
        .host_addr_rd(host_addr_rd), .host_half_second(host_half_second),
        .host_wdata(host_wdata), .host_rdata(host_rdata), .halfword_order(halfword_order));

    always #2.5 pclk = ~pclk;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic test_done();
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial
    begin
        #100000;
        err_total++;
        test_done();
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        rng = 32'h00000042;
        wr_m = `HPA_ADDR_RST;
        rd_m = `HPA_ADDR_RST;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `HPA_OFF_WR_ADDR, 32'h0);
        chk(r, wr_m);
        apb(1'b0, `HPA_OFF_RD_ADDR, 32'h0);
        chk(r, rd_m);
        apb(1'b1, 12'h00c, xs());
        chk(e, 32'h1);
        apb(1'b1, `HPA_OFF_CTRL, 32'hffffffff);
        apb(1'b0, `HPA_OFF_CTRL, 32'h0);
        chk(r, `HPA_CTRL_MASK);
        for (int i = 0; i < 8; i++)
        begin
            wr_m = xs() & 32'hfffffffc;
            rd_m = xs() & 32'hfffffffc;
            apb(1'b1, `HPA_OFF_WR_ADDR, wr_m);
            apb(1'b1, `HPA_OFF_RD_ADDR, rd_m);
            apb(1'b0, `HPA_OFF_WR_ADDR, 32'h0);
            chk(r, wr_m);
            apb(1'b0, `HPA_OFF_RD_ADDR, 32'h0);
            chk(r, rd_m);
            apb(1'b1, `HPA_OFF_CTRL, {20'h0, i[2], 1'b0, i[1], 8'h00, i[0]});
            @(negedge pclk);
            chk(halfword_order, i[0]);
            chk(dual_address_enable, i[1]);
            v = xs() & 32'hfffffffc;
            host_u.put(v);
            if (!i[1])
            begin
                wr_m = v;
                rd_m = v;
            end
            else if (i[2])
                rd_m = v;
            else
                wr_m = v;
            chk(write_address, wr_m);
            chk(read_address, rd_m);
            host_u.get(v);
            chk(v, (i[1] && i[2]) ? rd_m : wr_m);
        end
        test_done();
    end
endmodule : testbench

`default_nettype wire
